/* File: shared/wdt_pkg.sv */
// holds constants and types shared by the watchdog design files
// assumes a single 10 MHz clock and a synchronous host I/O strobe bus
package wdt_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] CTRL_PORT      = 16'h0455;
  localparam int          ARM_BIT        = 7;
  localparam logic [7:0]  CTRL_RESET_VAL = 8'h00;
  localparam logic [6:0]  RESERVED_READ  = 7'h00;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TIMEOUT_NS     = 1100000000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYCLES    = 16;
  localparam int          COUNT_W        = 24;
  localparam int          HOLD_W         = 8;
  // ==========================================================
  // states, gray along idle -> armed -> firing
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_FIRING = 2'b11
  } state_type;
endpackage

/* File: shared/wdt_cnt_if.sv */
// holds the link between watchdog control and its timeout counter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface wdt_cnt_if;
  import wdt_pkg::*;
  logic               clear;
  logic               run;
  logic               expired;
  logic [COUNT_W-1:0] count;
  modport ctl (output clear, output run, input expired, input count);
  modport tmr (input clear, input run, output expired, output count);
endinterface

/* File: hw/wdt_counter.sv */
// holds the watchdog timeout counter
// assumes clear and run come from logic on the same clock
`timescale 1ns/1ps
module wdt_counter #(
  parameter int unsigned LIMIT = wdt_pkg::TIMEOUT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  wdt_cnt_if.tmr    cnt
);
  import wdt_pkg::*;

  localparam logic [COUNT_W-1:0] LAST = COUNT_W'(LIMIT - 1);

  // ==========================================================
  // counter
  assign cnt.expired = cnt.run && (cnt.count == LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt.count <= '0;
    end else if (cnt.clear || !cnt.run || cnt.expired) begin
      cnt.count <= '0;
    end else begin
      cnt.count <= cnt.count + 1'b1;
    end
  end

  // ==========================================================
  // checks
  property p_expire_at_limit;
    @(posedge mclk) disable iff (rst)
      cnt.run && !cnt.clear && (cnt.count == LAST) |-> cnt.expired ##1 (cnt.count == '0);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit)
    else $error("expiry not at the timeout count");

  property p_clear_restarts;
    @(posedge mclk) disable iff (rst)
      cnt.clear |=> (cnt.count == '0);
  endproperty
  a_clear_restarts: assert property (p_clear_restarts)
    else $error("clear did not restart the count");
endmodule

/* File: hw/wdt_top.sv */
// holds the I/O mapped watchdog control register and reset generator
// assumes host I/O strobes are one-cycle pulses synchronous to mclk
`timescale 1ns/1ps
// Contract
// - An armed watchdog that is not refreshed before timeout drives a board reset.
// - The timeout is nominally 1.1 s, allowed between 550 ms and 1.65 s.
// - With the firmware enable off the register is not decoded and no reset occurs.
// - Turning the firmware enable on leaves the watchdog disarmed until a write arms it.
// - Writing one to bit 7 of port 0x455 arms the watchdog.
// - Writing zero to bit 7 of port 0x455 disarms it so no reset follows.
// - Any read of port 0x455 refreshes the watchdog and restarts the timeout.
module wdt_top #(
  parameter int unsigned TIMEOUT = wdt_pkg::TIMEOUT_CYCLES,
  parameter int unsigned HOLD    = wdt_pkg::HOLD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        cfg_enable,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_valid,
  output logic             board_reset,
  output logic             armed
);
  import wdt_pkg::*;

  // ==========================================================
  // decode
  function automatic logic port_hit(input logic [15:0] a, input logic en);
    port_hit = en && (a == CTRL_PORT);
  endfunction

  state_type         state;
  state_type         next_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic              rd_hit;
  logic              wr_hit;
  logic              arm_wr;
  logic              disarm_wr;

  wdt_cnt_if cnt ();

  assign rd_hit    = io_rd && port_hit(io_addr, cfg_enable);
  assign wr_hit    = io_wr && port_hit(io_addr, cfg_enable);
  assign arm_wr    = wr_hit && io_wdata[ARM_BIT];
  assign disarm_wr = wr_hit && !io_wdata[ARM_BIT];

  // ==========================================================
  // counter control
  assign cnt.clear = arm_wr || rd_hit;
  assign cnt.run   = (state == ST_ARMED);

  wdt_counter #(
    .LIMIT (TIMEOUT)
  ) u_counter (
    .mclk (mclk),
    .rst  (rst),
    .cnt  (cnt)
  );

  // ==========================================================
  // state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arm_wr) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!cfg_enable) begin
          next_state = ST_IDLE;
        end else if (disarm_wr) begin
          next_state = ST_IDLE;
        end else if (cnt.expired && !rd_hit && !arm_wr) begin
          next_state = ST_FIRING;
        end
      end
      ST_FIRING: begin
        if (!cfg_enable || hold_cnt == HOLD_W'(HOLD - 1)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (state == ST_FIRING) begin
      hold_cnt <= hold_cnt + 1'b1;
    end else begin
      hold_cnt <= '0;
    end
  end

  assign board_reset = (state == ST_FIRING);
  assign armed       = (state == ST_ARMED);

  // ==========================================================
  // read data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_rdata       <= CTRL_RESET_VAL;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= rd_hit;
      io_rdata       <= rd_hit ? {armed, RESERVED_READ} : CTRL_RESET_VAL;
    end
  end

  // ==========================================================
  // checks
  property p_fire_needs_armed;
    @(posedge mclk) disable iff (rst)
      $rose(board_reset) |-> $past(state) == ST_ARMED && $past(cnt.expired);
  endproperty
  a_fire_needs_armed: assert property (p_fire_needs_armed)
    else $error("board reset without an armed expiry");

  property p_cfg_off_quiet;
    @(posedge mclk) disable iff (rst)
      !cfg_enable |=> !armed && !board_reset;
  endproperty
  a_cfg_off_quiet: assert property (p_cfg_off_quiet)
    else $error("watchdog active while firmware enable is off");

  property p_no_decode_off;
    @(posedge mclk) disable iff (rst)
      !cfg_enable |=> !io_rdata_valid;
  endproperty
  a_no_decode_off: assert property (p_no_decode_off)
    else $error("register answered while firmware enable is off");

  property p_enable_stays_disarmed;
    @(posedge mclk) disable iff (rst)
      $rose(cfg_enable) && !io_wr |=> !armed;
  endproperty
  a_enable_stays_disarmed: assert property (p_enable_stays_disarmed)
    else $error("enabling armed the watchdog");

  property p_arm_write;
    @(posedge mclk) disable iff (rst)
      arm_wr && state == ST_IDLE |=> armed && (cnt.count == '0);
  endproperty
  a_arm_write: assert property (p_arm_write)
    else $error("arm write did not arm");

  property p_disarm_write;
    @(posedge mclk) disable iff (rst)
      disarm_wr && state == ST_ARMED |=> (!armed && !board_reset) ##1 !board_reset;
  endproperty
  a_disarm_write: assert property (p_disarm_write)
    else $error("disarm write left the watchdog live");

  property p_read_refresh;
    @(posedge mclk) disable iff (rst)
      rd_hit && armed && cfg_enable && !io_wr |=> cnt.count == '0 && !board_reset;
  endproperty
  a_read_refresh: assert property (p_read_refresh)
    else $error("read did not refresh the watchdog");

  property p_read_data;
    @(posedge mclk) disable iff (rst)
      rd_hit |=> io_rdata_valid && io_rdata[6:0] == RESERVED_READ
        && io_rdata[ARM_BIT] == $past(armed);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("control read returned wrong data");

  property p_arm_clears;
    @(posedge mclk) disable iff (rst)
      arm_wr |=> cnt.count == '0;
  endproperty
  a_arm_clears: assert property (p_arm_clears)
    else $error("arming did not clear the counter");
endmodule

/* File: dv/host_io_model.sv */
// host software model driving the watchdog I/O strobe bus
// assumes strobes change on the falling edge of mclk
`timescale 1ns/1ps
module host_io_model
  import wdt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rdata_valid,
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  io_wdata
);
  // ==========================================================
  // bus cycles
  initial begin
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // a read also refreshes the watchdog
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
    v = io_rdata_valid;
  endtask
  // arm bit change by read-modify-write
  task automatic set_arm(input logic on);
    logic [7:0] d;
    logic       v;
    rd(CTRL_PORT, d, v);
    wr(CTRL_PORT, {on, d[6:0]});
  endtask
endmodule

/* File: dv/io_mapped_watchdog_timer_test.sv */
// self-checking bench for the watchdog top
// assumes the host model above and a shortened timeout
`timescale 1ns/1ps
module io_mapped_watchdog_timer_test;
  import wdt_pkg::*;
  localparam int TMO = 20;
  localparam int HLD = 8;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_enable = 1'b1;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_rdata_valid;
  logic        board_reset;
  logic        armed;
  logic [7:0]  d;
  logic        v;
  int          err_total = 0;
  int          compares = 0;
  int          fires = 0;
  int          n;
  always #50 mclk = ~mclk;
  always @(posedge board_reset) fires++;
  wdt_top #(.TIMEOUT(TMO), .HOLD(HLD)) u_dut (.mclk(mclk), .rst(rst),
    .cfg_enable(cfg_enable), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .board_reset(board_reset), .armed(armed));
  host_io_model u_host (.mclk(mclk), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata));
  // ==========================================================
  // checking
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk({7'h00, armed}, 8'h00);
    u_host.rd(CTRL_PORT, d, v);
    chk(d, CTRL_RESET_VAL);
    chk({7'h00, v}, 8'h01);
  endtask
  task automatic t_arm;
    u_host.wr(CTRL_PORT, 8'hFF);
    chk({7'h00, armed}, 8'h01);
    u_host.rd(CTRL_PORT, d, v);
    chk(d, 8'h80);
    u_host.wr(CTRL_PORT, 8'h7F);
    chk({7'h00, armed}, 8'h00);
  endtask
  task automatic t_refresh;
    u_host.set_arm(1'b1);
    repeat (5) begin
      repeat (TMO / 2 - 2) @(negedge mclk);
      u_host.rd(CTRL_PORT, d, v);
    end
    chk(fires[7:0], 8'h00);
    // refresh lands in the very cycle of expiry
    repeat (TMO - 2) @(negedge mclk);
    u_host.rd(CTRL_PORT, d, v);
    chk(fires[7:0], 8'h00);
    u_host.set_arm(1'b0);
    repeat (2 * TMO) @(negedge mclk);
    chk(fires[7:0], 8'h00);
  endtask
  task automatic t_expire;
    u_host.set_arm(1'b1);
    repeat (TMO / 2) @(negedge mclk);
    u_host.wr(CTRL_PORT, 8'h80);
    for (n = 0; n < 2 * TMO && board_reset !== 1'b1; n++) @(negedge mclk);
    if (n >= 2 * TMO) begin
      err_total++;
    end else begin
      chk({7'h00, n >= TMO / 2 - 1 && n <= TMO * 3 / 2}, 8'h01);
      chk({7'h00, armed}, 8'h00);
      repeat (HLD - 1) @(negedge mclk);
      chk({7'h00, board_reset}, 8'h01);
      repeat (3) @(negedge mclk);
      chk({7'h00, board_reset}, 8'h00);
    end
  endtask
  task automatic t_cfg;
    u_host.wr(16'h0456, 8'h80);
    chk({7'h00, armed}, 8'h00);
    u_host.set_arm(1'b1);
    cfg_enable = 1'b0;
    u_host.wr(CTRL_PORT, 8'h80);
    chk({7'h00, armed}, 8'h00);
    u_host.rd(CTRL_PORT, d, v);
    chk({7'h00, v}, 8'h00);
    n = fires;
    repeat (2 * TMO) @(negedge mclk);
    chk(fires[7:0], n[7:0]);
    cfg_enable = 1'b1;
    repeat (2 * TMO) @(negedge mclk);
    chk({7'h00, armed}, 8'h00);
    chk(fires[7:0], n[7:0]);
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_arm();
    t_refresh();
    t_expire();
    t_cfg();
    results();
  end
endmodule
